/* File: rtl/fcs_sequencer.v */
// flash command sequencer with axi4-lite register and array window
//
// Operation
// - security register bit0 read/write, set by reset, upper bits zero
// - word writes deliver commands; device programs on its own afterwards
// - read mode after reset and normal completion; array read in every state but auto operation and id query
// - recognised command enters auto mode; id query stays in query state
// - no array reads served while auto operation runs
// - out-of-order write cycle abandons sequence, back to read mode
// - read or read/reset command cancels partial sequence
// - last write clears done flag; completion sets it, read mode
// - new command writes ignored while auto operation runs
// - page program stays within one page
// - programming only clears bits; erase needed to set them
// - protected block contents are never changed by programming
// - three command cycles, then page words from the fourth cycle
// - no internal verify after programming
// - done flag at bit 0 of control status register
// - failed operation keeps done flag low until hardware reset
// - security write needs key word then data within sixteen clocks
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.vh"
module fcs_sequencer #(
  parameter AW        = 6,
  parameter PAGE_BITS = 2,
  parameter BLK_BITS  = 2
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  block_protect,
  input  wire        erase_all,
  output wire        op_fail,
  output wire        security_enable
);
  // ****************************************************************
  // address map: bit 15 selects the flash window, else registers
  // ****************************************************************
  localparam PAGE_WORDS = 1 << PAGE_BITS;
  localparam [15:0] PROG_CYC = `FCS_WORD_PROG_CYC;
  localparam ST_READ = 5'b00001;
  localparam ST_C2   = 5'b00010;
  localparam ST_C3   = 5'b00100;
  localparam ST_PAGE = 5'b01000;
  localparam ST_BUSY = 5'b10000;

  function is_flash;
    input [15:0] a;
    is_flash = a[15];
  endfunction

  function [7:0] cmd_addr;
    input [15:0] a;
    cmd_addr = a[13:6];
  endfunction

  // ****************************************************************
  // write channel capture
  // ****************************************************************
  reg        aw_have_reg;
  reg [15:0] aw_addr_reg;
  reg        w_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire word_wr = (w_strb_reg == 4'hf);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      aw_have_reg  <= 1'b0;
      aw_addr_reg  <= 16'h0000;
      w_have_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (is_flash(aw_addr_reg) ||
            aw_addr_reg[11:0] == `FCS_SEC_OFFSET ||
            aw_addr_reg[11:0] == `FCS_CTL_OFFSET) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // security register with key unlock
  // ****************************************************************
  reg       sec_reg;
  reg [4:0] key_cnt_reg;
  wire sec_wr = wr_go && !is_flash(aw_addr_reg) &&
                aw_addr_reg[11:0] == `FCS_SEC_OFFSET && word_wr;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sec_reg     <= `FCS_SEC_RESET;
      key_cnt_reg <= 5'h00;
    end else begin
      if (key_cnt_reg != 5'h00) begin
        key_cnt_reg <= key_cnt_reg - 5'h01;
      end
      if (sec_wr && w_data_reg == `FCS_SEC_KEY) begin
        key_cnt_reg <= `FCS_SEC_WINDOW;
      end else if (sec_wr && key_cnt_reg != 5'h00) begin
        sec_reg     <= w_data_reg[0];
        key_cnt_reg <= 5'h00;
      end
    end
  end
  assign security_enable = sec_reg;

  // ****************************************************************
  // command state machine
  // ****************************************************************
  reg [4:0]          st_reg;
  reg                id_mode_reg;
  reg                done_reg;
  reg                fail_reg;
  reg [PAGE_BITS:0]  wcnt_reg;
  reg [AW-1:0]       pbase_reg;
  reg [31:0]         pbuf_reg [0:PAGE_WORDS-1];
  reg [PAGE_BITS:0]  pcnt_reg;
  reg [15:0]         tcnt_reg;
  reg                prot_reg;
  wire fl_wr = wr_go && is_flash(aw_addr_reg);
  wire [7:0] ca = cmd_addr(aw_addr_reg);
  wire [7:0] cd = w_data_reg[7:0];
  wire sw_reset = fl_wr && cd == `FCS_CMD_RESET;
  wire [AW-1:0] w_idx = aw_addr_reg[AW+1:2];
  wire [BLK_BITS-1:0] w_blk = w_idx[AW-1:AW-BLK_BITS];
  wire arr_wr = (st_reg == ST_BUSY) && !prot_reg && tcnt_reg == 16'h0001;
  wire [AW-1:0] arr_wr_idx = pbase_reg | pcnt_reg[PAGE_BITS-1:0];
  integer k;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg      <= ST_READ;
      id_mode_reg <= 1'b0;
      done_reg    <= 1'b1;
      fail_reg    <= 1'b0;
      wcnt_reg    <= {(PAGE_BITS+1){1'b0}};
      pbase_reg   <= {AW{1'b0}};
      pcnt_reg    <= {(PAGE_BITS+1){1'b0}};
      tcnt_reg    <= 16'h0000;
      prot_reg    <= 1'b0;
      for (k = 0; k < PAGE_WORDS; k = k + 1) begin
        pbuf_reg[k] <= 32'h0000_0000;
      end
    end else begin
      case (st_reg)
        ST_READ: begin
          if (fl_wr && word_wr) begin
            if (sw_reset) begin
              id_mode_reg <= 1'b0;
            end else if (ca == `FCS_ADDR_A && cd == `FCS_DATA_1) begin
              st_reg <= ST_C2;
            end
          end
        end
        ST_C2: begin
          if (fl_wr) begin
            if (word_wr && ca == `FCS_ADDR_B && cd == `FCS_DATA_2) begin
              st_reg <= ST_C3;
            end else begin
              st_reg <= ST_READ;
            end
          end
        end
        ST_C3: begin
          if (fl_wr) begin
            st_reg <= ST_READ;
            if (word_wr && ca == `FCS_ADDR_A) begin
              if (cd == `FCS_CMD_PROG) begin
                st_reg   <= ST_PAGE;
                wcnt_reg <= {(PAGE_BITS+1){1'b0}};
              end else if (cd == `FCS_CMD_ID) begin
                id_mode_reg <= 1'b1;
              end else if (cd == `FCS_CMD_RESET) begin
                id_mode_reg <= 1'b0;
              end
            end
          end
        end
        ST_PAGE: begin
          if (fl_wr) begin
            if (!word_wr || sw_reset ||
                (wcnt_reg != 0 &&
                 w_idx[AW-1:PAGE_BITS] != pbase_reg[AW-1:PAGE_BITS]) ||
                w_idx[PAGE_BITS-1:0] != wcnt_reg[PAGE_BITS-1:0]) begin
              st_reg <= ST_READ;
            end else begin
              pbuf_reg[wcnt_reg[PAGE_BITS-1:0]] <= w_data_reg;
              if (wcnt_reg == 0) begin
                pbase_reg <= {w_idx[AW-1:PAGE_BITS],
                              {PAGE_BITS{1'b0}}};
                prot_reg  <= block_protect[w_blk];
              end
              wcnt_reg <= wcnt_reg + 1'b1;
              if (wcnt_reg == PAGE_WORDS - 1) begin
                st_reg   <= ST_BUSY;
                done_reg <= 1'b0;
                pcnt_reg <= {(PAGE_BITS+1){1'b0}};
                tcnt_reg <= PROG_CYC;
              end
            end
          end
        end
        ST_BUSY: begin
          // writes here are dropped
          if (prot_reg) begin
            fail_reg <= 1'b1;
          end else if (tcnt_reg > 16'h0001) begin
            tcnt_reg <= tcnt_reg - 16'h0001;
          end else if (pcnt_reg == PAGE_WORDS - 1) begin
            st_reg   <= ST_READ;
            done_reg <= 1'b1;
          end else begin
            pcnt_reg <= pcnt_reg + 1'b1;
            tcnt_reg <= PROG_CYC;
          end
        end
        default: begin
          st_reg <= ST_READ;
        end
      endcase
    end
  end
  assign op_fail = fail_reg;

  wire [31:0] arr_data;
  fcs_array #(
    .AW (AW)
  ) u_array (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .wr_en     (arr_wr),
    .wr_idx    (arr_wr_idx),
    .wr_data   (pbuf_reg[pcnt_reg[PAGE_BITS-1:0]]),
    .erase_all (erase_all && st_reg == ST_READ),
    .rd_idx    (s_axi_araddr[AW+1:2]),
    .rd_data   (arr_data)
  );

  // ****************************************************************
  // read channel: array data waits one cycle for the array register
  // ****************************************************************
  reg        r_wait_reg;
  reg [15:0] r_addr_reg;
  assign s_axi_arready = !s_axi_rvalid && !r_wait_reg;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      r_wait_reg   <= 1'b0;
      r_addr_reg   <= 16'h0000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        r_wait_reg <= 1'b1;
        r_addr_reg <= s_axi_araddr;
      end
      if (r_wait_reg) begin
        r_wait_reg   <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        s_axi_rdata  <= 32'h0000_0000;
        if (is_flash(r_addr_reg)) begin
          if (st_reg == ST_BUSY) begin
            s_axi_rresp <= 2'b10;
          end else if (id_mode_reg) begin
            s_axi_rdata <= 32'h0000_0000;
          end else begin
            s_axi_rdata <= arr_data;
          end
        end else if (r_addr_reg[11:0] == `FCS_SEC_OFFSET) begin
          s_axi_rdata <= {31'h0000_0000, sec_reg};
        end else if (r_addr_reg[11:0] == `FCS_CTL_OFFSET) begin
          s_axi_rdata <= {12'h000, block_protect, 15'h0000,
                          done_reg};
        end else begin
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // fcs_sequencer
`default_nettype wire

/* File: inc/fcs_regs.vh */
// register offsets, fields, command codes and timing for the flash sequencer
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// ****************************************************************
// register map
// ****************************************************************
`define FCS_SEC_OFFSET     12'h010
`define FCS_CTL_OFFSET     12'h020
`define FCS_SEC_KEY        32'ha74a_9d23
`define FCS_SEC_WINDOW     5'h10
`define FCS_SEC_RESET      1'b1
`define FCS_RDY_BIT        0
`define FCS_PROT_LSB       16
// ****************************************************************
// command cycles
// ****************************************************************
`define FCS_ADDR_A         8'h55
`define FCS_ADDR_B         8'haa
`define FCS_DATA_1         8'haa
`define FCS_DATA_2         8'h55
`define FCS_CMD_PROG       8'ha0
`define FCS_CMD_ID         8'h90
`define FCS_CMD_RESET      8'hf0
`define FCS_ERASED_WORD    32'hffff_ffff
// ****************************************************************
// timing
// ****************************************************************
`define FCS_CLK_MHZ        100
`define FCS_WORD_PROG_NS   1000
`define FCS_WORD_PROG_CYC  ((`FCS_WORD_PROG_NS * `FCS_CLK_MHZ) / 1000)
`endif

/* File: rtl/fcs_array.v */
// flash cell array: program may only pull bits low, erase sets all high
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.vh"
module fcs_array #(
  parameter AW = 6
) (
  input  wire          core_clk,
  input  wire          rst_n,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_idx,
  input  wire [31:0]   wr_data,
  input  wire          erase_all,
  input  wire [AW-1:0] rd_idx,
  output reg  [31:0]   rd_data
);
  reg [31:0] cell_reg [0:(1<<AW)-1];
  integer i;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= cell_reg[rd_idx];
    end
    if (erase_all) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        cell_reg[i] <= `FCS_ERASED_WORD;
      end
    end else if (wr_en) begin
      cell_reg[wr_idx] <= cell_reg[wr_idx] & wr_data;
    end
  end
endmodule // fcs_array
`default_nettype wire

/* File: verification/fcs_sequencer_assertions.sv */
// port assertions for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [3:0]  block_protect,
  input wire logic        op_fail,
  input wire logic        security_enable
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire ar_ok = s_axi_arvalid && s_axi_arready;
  wire ctl_rd = ar_ok && !s_axi_araddr[15] && s_axi_araddr[11:0] == 12'h020;
  property p_sec_reset;
    $rose(rst_n) |-> security_enable;
  endproperty
  a_sec_reset: assert property (p_sec_reset)
    else $error("security bit low after reset");
  property p_sec_write;
    $changed(security_enable) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_sec_write: assert property (p_sec_write)
    else $error("security bit changed without a write");
  property p_fail_sticky;
    op_fail |=> op_fail;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("failure flag dropped before reset");
  property p_fail_busy;
    op_fail && ctl_rd |-> ##2 !s_axi_rdata[0];
  endproperty
  a_fail_busy: assert property (p_fail_busy)
    else $error("done flag high after failure");
  property p_ctl_read;
    ctl_rd |-> ##2 s_axi_rdata[31:1] == {12'h000, block_protect, 15'h0000};
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control status read wrong");
  property p_unmapped;
    ar_ok && !s_axi_araddr[15] && s_axi_araddr[11:0] != 12'h010
      && s_axi_araddr[11:0] != 12'h020 |-> ##2 s_axi_rresp == 2'b10;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_read_answer;
    ar_ok |-> ##1 !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write answer late");
  property p_write_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_refuse: assert property (p_write_refuse)
    else $error("write taken while answer pending");
endmodule // fcs_sequencer_checker
bind fcs_sequencer fcs_sequencer_checker fcs_sequencer_checker_i (.*);
`default_nettype wire

/* File: verification/fcs_host.sv */
// bus master model standing in for the reprogramming routine
`timescale 1ns/1ns
`default_nettype none
module fcs_host (
  input  wire logic        core_clk,
  output var  logic [15:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [15:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  // ****************************************************************
  // one transfer at a time, each a whole word
  // ****************************************************************
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
  initial {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [1:0] r,
                      output logic [31:0] q);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid));
    r = w ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
endmodule // fcs_host
`default_nettype wire

/* File: verification/fcs_sequencer_test.sv */
// self-checking bench for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer_test;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] e;
  } fcs_row_t;
  logic        core_clk, rst_n, erase_all, op_fail, security_enable;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb, block_protect;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  int          bad_count = 0;
  int          n_compared = 0;
  fcs_row_t    rows [10] = '{
    '{1'b0, 16'h0010, 32'h0, 2'b00, 32'h1},
    '{1'b1, 16'h0030, 32'h0, 2'b10, 32'h0},
    '{1'b0, 16'h0020, 32'h0, 2'b00, 32'h0008_0001},
    '{1'b0, 16'h0030, 32'h0, 2'b10, 32'h0},
    '{1'b1, 16'h0010, 32'h0, 2'b00, 32'h0},
    '{1'b0, 16'h0010, 32'h0, 2'b00, 32'h1},
    '{1'b1, 16'h0010, 32'ha74a_9d23, 2'b00, 32'h0},
    '{1'b1, 16'h0010, 32'h0, 2'b00, 32'h0},
    '{1'b0, 16'h0010, 32'h0, 2'b00, 32'h0},
    '{1'b0, 16'h8010, 32'h0, 2'b00, 32'hffff_ffff}};
  fcs_sequencer fcs_sequencer_i (.*);
  fcs_host      fcs_host_i (.*);
  // ****************************************************************
  // tasks and sequences
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'b00);
    fcs_host_i.xfer(1'b1, a, d, r, q);
    chk("bresp", r, er);
  endtask
  task automatic rd(input logic [15:0] a, input logic [1:0] er,
                    input logic [31:0] e);
    fcs_host_i.xfer(1'b0, a, 32'h0, r, q);
    chk("rresp", r, er);
    if (er == 2'b00) chk("rdata", q, e);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(16'h9540, 32'h00aa);
    wr(16'haa80, 32'h0055);
    wr(16'h9540, {24'h0, c});
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      fcs_host_i.xfer(1'b0, 16'h0020, 32'h0, r, q);
      n++;
    end while (q[0] !== 1'b1 && n < 300);
    chk("done", q, 32'h0008_0001);
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    test_done;
  end
  initial begin
    rst_n = 1'b0;
    erase_all = 1'b0;
    block_protect = 4'b1000;
    do_reset;
    erase_all <= 1'b1;
    @(posedge core_clk);
    erase_all <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
      else rd(rows[i].a, rows[i].r, rows[i].e);
    end
    chk("security_enable", security_enable, 32'h0);
    rd(16'h0020, 2'b00, 32'h0008_0001);
    cmd(8'ha0);
    for (int i = 0; i < 4; i++)
      wr(16'(16'h8010 + 4 * i),
         i == 3 ? 32'hffff_ffff : 32'h1234_5670 + i);
    rd(16'h0020, 2'b00, 32'h0008_0000);
    rd(16'h8010, 2'b10, 32'h0);
    cmd(8'ha0);
    for (int i = 0; i < 4; i++) wr(16'(16'h8020 + 4 * i), 32'h0);
    wait_done;
    repeat (20000) @(posedge core_clk);
    for (int i = 0; i < 4; i++)
      rd(16'(16'h8010 + 4 * i), 2'b00,
         i == 3 ? 32'hffff_ffff : 32'h1234_5670 + i);
    rd(16'h8020, 2'b00, 32'hffff_ffff);
    wr(16'h9540, 32'h00aa);
    wr(16'haa80, 32'h0055);
    wr(16'h8000, 32'h00f0);
    wr(16'h9540, 32'h00a0);
    wr(16'h8030, 32'h0);
    rd(16'h8030, 2'b00, 32'hffff_ffff);
    wr(16'h9540, 32'h00aa);
    wr(16'h9540, 32'h0055);
    cmd(8'ha0);
    wr(16'h8030, 32'h0);
    wr(16'h8000, 32'h00f0);
    rd(16'h8030, 2'b00, 32'hffff_ffff);
    cmd(8'ha0);
    wr(16'h8030, 32'h0);
    for (int i = 1; i < 4; i++) wr(16'(16'h8040 + 4 * i), 32'h0);
    rd(16'h8030, 2'b00, 32'hffff_ffff);
    cmd(8'h90);
    rd(16'h8010, 2'b00, 32'h0);
    wr(16'h8000, 32'h00f0);
    rd(16'h8010, 2'b00, 32'h1234_5670);
    cmd(8'h90);
    cmd(8'hf0);
    rd(16'h8010, 2'b00, 32'h1234_5670);
    cmd(8'ha0);
    for (int i = 0; i < 4; i++) wr(16'(16'h80c0 + 4 * i), 32'h0);
    repeat (600) @(posedge core_clk);
    chk("op_fail", op_fail, 32'h1);
    rd(16'h0020, 2'b00, 32'h0008_0000);
    do_reset;
    rd(16'h0020, 2'b00, 32'h0008_0001);
    rd(16'h80c0, 2'b00, 32'hffff_ffff);
    chk("security_enable", security_enable, 32'h1);
    test_done;
  end
endmodule // fcs_sequencer_test
`default_nettype wire
